//--- include/ubd_consts.svh
// Constants for the bulk double-buffer endpoint controller.
// Assumes inclusion by bare name from the include directory.
`ifndef UBD_CONSTS_SVH
`define UBD_CONSTS_SVH
// Byte offsets of the registers on the Avalon-MM slave.
`define UBD_OFS_EPCTRL 4'h0
`define UBD_OFS_STATUS 4'h4
`define UBD_OFS_RXLEN0 4'h8
`define UBD_OFS_RXLEN1 4'hc
// Bit positions inside the endpoint control register.
`define UBD_BIT_TX_STAT 4
`define UBD_BIT_TX_TOG 6
`define UBD_BIT_TX_DONE 7
`define UBD_BIT_KIND 8
`define UBD_BIT_TYPE 9
`define UBD_BIT_RX_STAT 12
`define UBD_BIT_RX_TOG 14
`define UBD_BIT_RX_DONE 15
// Reset values.
`define UBD_EPCTRL_RST 16'h0000
`define UBD_LEN_RST 10'h000
`endif

//--- include/ubd_pkg.sv
// Types shared by the bulk double-buffer endpoint controller.
// Assumes the constants header is on the include path.
package ubd_pkg;
   // Endpoint status pair codes.
   typedef enum logic [1:0] {
      UBD_DISABLED = 2'h0,
      UBD_STALL = 2'h1,
      UBD_NAK = 2'h2,
      UBD_VALID = 2'h3
   } ubd_stat_t;
   // Handshake answered to a token.
   typedef enum logic [1:0] {
      UBD_HS_NONE = 2'h0,
      UBD_HS_ACK = 2'h1,
      UBD_HS_NAK = 2'h2,
      UBD_HS_STALL = 2'h3
   } ubd_hs_t;
   // Token from the link engine.
   typedef struct packed {
      logic isIn;
      logic valid;
   } ubd_token_t;
   // Transaction end report from the link engine.
   typedef struct packed {
      logic ok;
      logic valid;
      logic [9:0] count;
   } ubd_done_t;
endpackage

//--- rtl/ubd_decide.sv
// Combinational status decision for one token.
// Assumes inputs from registers on the same clock.
`timescale 1ns/1ps
module ubd_decide (
   input wire ubd_pkg::ubd_stat_t stat,
   input wire logic dblActive,
   input wire logic devToggle,
   input wire logic appFlag,
   output logic [1:0] effStat,
   output logic useBuf
);
   import ubd_pkg::*;
   // The stored status is masked as NAK on a buffer conflict only when it is Valid.
   always_comb begin
      effStat = stat;
      if (dblActive && stat == UBD_VALID && devToggle == appFlag) begin
         effStat = UBD_NAK;
      end
      // A programmed non-Valid status always wins over the comparison.
      useBuf = (effStat == UBD_VALID);
   end
endmodule

//--- rtl/ubd_avmm.sv
// Avalon-MM register slave front end, one wait state on each access.
// Assumes a master that holds its request until waitrequest is low.
`timescale 1ns/1ps
module ubd_avmm (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic avsRead,
   input wire logic avsWrite,
   output logic avsWaitrequest,
   output logic accept
);
   logic ack_r; // Answer cycle marker.
   // Each request waits one cycle, then is taken on the following edge.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avsRead || avsWrite) && !ack_r;
      end
   end
   assign avsWaitrequest = !ack_r;
   assign accept = ack_r && (avsRead || avsWrite);
endmodule

//--- rtl/ubd_bulk_ctrl.sv
// Bulk double-buffer endpoint controller for one endpoint register.
// Assumes a link engine on core_clk that issues tokens and transaction ends.
// Function
// - Device buffer chosen by direction's toggle.
// - Other toggle is the application buffer flag.
// - Flag value picks descriptor pair.
// - Equal flags mask status to NAK.
// - First transaction uses normal status handling.
// - Transaction end sets direction done flag.
// - Transaction end toggles direction data toggle.
// - Active mode keeps status Valid at end.
// - Non-Valid programmed status always used.
// - Not-ready endpoint answers NAK.
// - Status codes: disabled, STALL, NAK, Valid.
// - Received count written back to descriptor.
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "ubd_consts.svh"
module ubd_bulk_ctrl (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [3:0] avsByteenable,
   output logic [31:0] avsReaddata,
   output logic avsWaitrequest,
   input wire ubd_pkg::ubd_token_t token,
   input wire ubd_pkg::ubd_done_t done,
   output ubd_pkg::ubd_hs_t handshake,
   output logic bufSel,
   output logic bufUse
);
   import ubd_pkg::*;

   logic accept; // Register access taken this cycle.
   logic wrEn; // Write taken with the low lanes enabled.
   logic [1:0] rxStat_r; // Receive status pair.
   logic [1:0] txStat_r; // Transmit status pair.
   logic rxTog_r; // Receive toggle, bit 14.
   logic txTog_r; // Transmit toggle, bit 6.
   logic rxDone_r; // Receive correct-transfer flag.
   logic txDone_r; // Transmit correct-transfer flag.
   logic kind_r; // Endpoint kind bit, double-buffer mode for bulk.
   logic [1:0] type_r; // Endpoint type field.
   logic dblActive_r; // Special flow control armed after first end.
   logic curIn_r; // Direction of the transaction in progress.
   logic [9:0] rxLen0_r; // Received count for descriptor pair 0.
   logic [9:0] rxLen1_r; // Received count for descriptor pair 1.
   logic [31:0] readdata_r; // Registered read data.
   logic dblMode; // Bulk type with kind bit set.
   logic isRxEp; // Endpoint enabled for reception.
   logic [1:0] dirStat; // Stored status of the token's direction.
   logic devTog; // Device toggle of the token's direction.
   logic appFlag; // Application flag of the token's direction.
   logic [1:0] effStat; // Status after conflict masking.
   logic useBuf; // Token will use a buffer.
   logic doneOk; // Successful transaction end.
   logic [15:0] wd; // Low half of write data.

   assign dblMode = (type_r == 2'h0) && kind_r;
   assign isRxEp = (rxStat_r != 2'h0);
   assign wd = avsWritedata[15:0];
   assign wrEn = accept && avsWrite && avsByteenable[0] && avsByteenable[1];
   assign doneOk = done.valid && done.ok;

   // Bus handshake with one wait state.
   ubd_avmm uAvmm (
      .core_clk(core_clk),
      .rst(rst),
      .avsRead(avsRead),
      .avsWrite(avsWrite),
      .avsWaitrequest(avsWaitrequest),
      .accept(accept)
   );

   // Pick status and toggles by token direction; rx toggle for rx, tx toggle for tx.
   always_comb begin
      if (token.isIn) begin
         dirStat = txStat_r;
         devTog = txTog_r;
         appFlag = rxTog_r;
      end else begin
         dirStat = rxStat_r;
         devTog = rxTog_r;
         appFlag = txTog_r;
      end
   end

   // Conflict masking and override.
   ubd_decide uDecide (
      .stat(ubd_stat_t'(dirStat)),
      .dblActive(dblActive_r && dblMode),
      .devToggle(devTog),
      .appFlag(appFlag),
      .effStat(effStat),
      .useBuf(useBuf)
   );

   // Handshake from the effective status code.
   always_comb begin
      handshake = UBD_HS_NONE;
      if (token.valid) begin
         unique case (ubd_stat_t'(effStat))
            UBD_DISABLED: handshake = UBD_HS_NONE;
            UBD_STALL: handshake = UBD_HS_STALL;
            UBD_NAK: handshake = UBD_HS_NAK;
            UBD_VALID: handshake = UBD_HS_ACK;
         endcase
      end
   end

   // Buffer select outputs; toggle value names the descriptor pair.
   always_comb begin
      bufSel = devTog;
      bufUse = token.valid && useBuf;
   end

   // Remember direction of the accepted token.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         curIn_r <= 1'b0;
      end else if (token.valid && useBuf) begin
         curIn_r <= token.isIn;
      end
   end

   // Mode, type and status fields; status Valid stays at end once active.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         type_r <= 2'h0;
         kind_r <= 1'b0;
         rxStat_r <= 2'h0;
         txStat_r <= 2'h0;
      end else begin
         if (wrEn) begin
            type_r <= wd[`UBD_BIT_TYPE +: 2];
            kind_r <= wd[`UBD_BIT_KIND];
            rxStat_r <= wd[`UBD_BIT_RX_STAT +: 2];
            txStat_r <= wd[`UBD_BIT_TX_STAT +: 2];
         end else if (doneOk && !(dblActive_r && dblMode)) begin
            // Normal handling switches the finished direction to NAK.
            if (curIn_r) begin
               txStat_r <= 2'h2;
            end else begin
               rxStat_r <= 2'h2;
            end
         end
         // With flow control active the status is left as written.
      end
   end

   // Double-buffer flow control arms at the first end in mode, drops with mode.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dblActive_r <= 1'b0;
      end else if (!dblMode) begin
         dblActive_r <= 1'b0;
      end else if (doneOk) begin
         dblActive_r <= 1'b1;
      end
   end

   // Toggles: a written one inverts, hardware toggles at end in the same cycle.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxTog_r <= 1'b0;
         txTog_r <= 1'b0;
      end else begin
         rxTog_r <= rxTog_r ^ (wrEn && wd[`UBD_BIT_RX_TOG])
            ^ (doneOk && !curIn_r);
         txTog_r <= txTog_r ^ (wrEn && wd[`UBD_BIT_TX_TOG])
            ^ (doneOk && curIn_r);
      end
   end

   // Done flags: writing zero clears, a new end in the same cycle wins.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxDone_r <= 1'b0;
         txDone_r <= 1'b0;
      end else begin
         rxDone_r <= (doneOk && !curIn_r)
            || (rxDone_r && !(wrEn && !wd[`UBD_BIT_RX_DONE]));
         txDone_r <= (doneOk && curIn_r)
            || (txDone_r && !(wrEn && !wd[`UBD_BIT_TX_DONE]));
      end
   end

   // Received count into the active descriptor pair.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxLen0_r <= `UBD_LEN_RST;
         rxLen1_r <= `UBD_LEN_RST;
      end else if (doneOk && !curIn_r) begin
         if (rxTog_r) begin
            rxLen1_r <= done.count;
         end else begin
            rxLen0_r <= done.count;
         end
      end
   end

   // Read data mux, loaded in the wait cycle so the data stand at the edge where
   // waitrequest is low; unmapped addresses read zero.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         readdata_r <= 32'h0000_0000;
      end else if (avsRead && avsWaitrequest) begin
         unique case (avsAddress)
            `UBD_OFS_EPCTRL: readdata_r <= {16'h0000, rxDone_r, rxTog_r, rxStat_r,
               1'b0, type_r, kind_r, txDone_r, txTog_r, txStat_r, 4'h0};
            `UBD_OFS_STATUS: readdata_r <= {30'h0000_0000, isRxEp, dblActive_r};
            `UBD_OFS_RXLEN0: readdata_r <= {22'h00_0000, rxLen0_r};
            `UBD_OFS_RXLEN1: readdata_r <= {22'h00_0000, rxLen1_r};
            default: readdata_r <= 32'h0000_0000;
         endcase
      end
   end
   assign avsReaddata = readdata_r;

   // Equal toggles in active mode with Valid status must answer NAK.
   a_conflict_nak: assert property (@(posedge core_clk) disable iff (rst)
      (token.valid && dblActive_r && dblMode && dirStat == 2'h3 && devTog == appFlag)
      |-> (handshake == UBD_HS_NAK && !bufUse)) else $error("conflict not NAKed");
   // A programmed STALL status is returned as a STALL handshake.
   a_override_stat: assert property (@(posedge core_clk) disable iff (rst)
      (token.valid && dirStat == 2'h1) |-> handshake == UBD_HS_STALL)
      else $error("override ignored");
   // Status stays Valid across an end once active.
   a_valid_kept: assert property (@(posedge core_clk) disable iff (rst)
      (doneOk && dblActive_r && dblMode && !wrEn && rxStat_r == 2'h3)
      |=> rxStat_r == 2'h3) else $error("status changed at end");
   // End before activation moves status to NAK.
   a_first_nak: assert property (@(posedge core_clk) disable iff (rst)
      (doneOk && !dblActive_r && !wrEn && !curIn_r) |=> rxStat_r == 2'h2)
      else $error("first end not NAK");
   // End toggles the direction's toggle.
   a_end_toggle: assert property (@(posedge core_clk) disable iff (rst)
      (doneOk && !curIn_r && !wrEn) |=> rxTog_r != $past(rxTog_r))
      else $error("toggle not flipped");
   // End sets the done flag even against a clear.
   a_done_set: assert property (@(posedge core_clk) disable iff (rst)
      (doneOk && curIn_r) |=> txDone_r) else $error("done flag lost");
   // Writing one flips the application flag.
   a_write_flip: assert property (@(posedge core_clk) disable iff (rst)
      (wrEn && wd[`UBD_BIT_TX_TOG] && !(doneOk && curIn_r)) |=> txTog_r != $past(txTog_r))
      else $error("write toggle failed");
   // Count lands in the selected descriptor.
   a_count_wb: assert property (@(posedge core_clk) disable iff (rst)
      (doneOk && !curIn_r && !rxTog_r) |=> rxLen0_r == $past(done.count))
      else $error("count not stored");
   // Buffer select follows the direction's toggle.
   a_buf_sel: assert property (@(posedge core_clk) disable iff (rst)
      (token.valid && !token.isIn) |-> bufSel == rxTog_r) else $error("wrong buffer");
   // NAK status gives NAK handshake.
   a_nak_hs: assert property (@(posedge core_clk) disable iff (rst)
      (token.valid && effStat == 2'h2) |-> handshake == UBD_HS_NAK)
      else $error("no NAK");
endmodule

//--- verification/ubd_host_model.sv
// Host-side link model that issues bulk tokens and transaction ends.
// Assumes the controller answers a token combinationally in the same cycle.
`timescale 1ns/1ps
module ubd_host_model (
   input wire logic core_clk,
   input wire ubd_pkg::ubd_hs_t handshake,
   input wire logic bufSel,
   input wire logic bufUse,
   output ubd_pkg::ubd_token_t token,
   output ubd_pkg::ubd_done_t done
);
   import ubd_pkg::*;
   // Lines start idle with no token and no transaction end.
   initial begin
      token = '0;
      done = '0;
   end
   // One token, then a transaction end only if a buffer was taken.
   task automatic xfer(input logic isIn, input int waitCyc, input logic ok,
         input logic [9:0] cnt, output ubd_hs_t hs, output logic sel, output logic taken);
      @(posedge core_clk);
      token <= '{isIn: isIn, valid: 1'b1};
      @(negedge core_clk);
      hs = handshake;
      sel = bufSel;
      taken = bufUse;
      @(posedge core_clk);
      // Idle direction line shows the inverse so a stale value is never trusted.
      token <= '{isIn: ~isIn, valid: 1'b0};
      // A refused token gets no end report; the bench retries it later.
      if (taken === 1'b1) begin
         repeat (waitCyc) @(posedge core_clk);
         done <= '{ok: ok, valid: 1'b1, count: cnt};
         @(posedge core_clk);
         done <= '{ok: 1'b0, valid: 1'b0, count: ~cnt};
      end
   endtask
endmodule

//--- verification/ubd_bulk_ctrl_tb.sv
// Self-checking bench for the bulk double-buffer endpoint controller.
// Assumes the package, the design files and the host model are compiled first.
`timescale 1ns/1ps
module ubd_bulk_ctrl_tb;
   import ubd_pkg::*;
   logic core_clk; // Core clock, 100 MHz.
   logic rst; // Asynchronous reset, active high.
   logic [3:0] avsAddress; // Register byte address.
   logic avsRead; // Read request.
   logic avsWrite; // Write request.
   logic [31:0] avsWritedata; // Write data.
   logic [3:0] avsByteenable; // Write lanes.
   logic [31:0] avsReaddata; // Read data.
   logic avsWaitrequest; // Slave stall.
   ubd_token_t token; // Token from the host model.
   ubd_done_t done; // Transaction end from the host model.
   ubd_hs_t handshake; // Answer to the token.
   logic bufSel; // Descriptor pair in device use.
   logic bufUse; // Token takes a buffer.
   int nErrors = 0; // Mismatch count.
   int comparisons = 0; // Comparison count.
   logic [31:0] rdData; // Last value read.
   // Handshake expected for status codes disabled, stall, nak and valid.
   ubd_hs_t statHs [4] = '{UBD_HS_NONE, UBD_HS_STALL, UBD_HS_NAK, UBD_HS_ACK};
   ubd_bulk_ctrl ubd_bulk_ctrl_inst (.core_clk(core_clk), .rst(rst), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
      .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest), .token(token), .done(done),
      .handshake(handshake), .bufSel(bufSel), .bufUse(bufUse));
   ubd_host_model ubd_host_model_inst (.core_clk(core_clk), .handshake(handshake),
      .bufSel(bufSel), .bufUse(bufUse), .token(token), .done(done));
   // Free-running clock.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         nErrors++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus access, held until the rising edge at which waitrequest is sampled low.
   task automatic avAccess(input logic isRd, input logic [3:0] a, input logic [15:0] d,
         input logic [3:0] be);
      int n;
      n = 0;
      @(posedge core_clk);
      avsAddress <= a;
      avsWritedata <= {16'h0000, d};
      avsByteenable <= be;
      avsRead <= isRd;
      avsWrite <= ~isRd;
      // Waitrequest and read data are taken as they stood at each rising edge.
      do begin
         @(posedge core_clk);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         nErrors++;
         $display("[FAIL] %0t ns: no bus answer", $time);
      end
      rdData = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask
   // Writes a control word on both low lanes.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      avAccess(1'b0, a, d, 4'hf);
   endtask
   // Reads a register and compares its low half.
   task automatic rdChk(input logic [3:0] a, input logic [15:0] e);
      avAccess(1'b1, a, 16'h0000, 4'hf);
      chk({16'h0000, rdData[15:0]}, {16'h0000, e});
   endtask
   // Runs one token and compares handshake, buffer choice and buffer use.
   task automatic tok(input logic isIn, input int w, input logic ok, input logic [9:0] cnt,
         input ubd_hs_t eHs, input logic eSel, input logic eUse);
      ubd_hs_t hs;
      logic sel;
      logic taken;
      ubd_host_model_inst.xfer(isIn, w, ok, cnt, hs, sel, taken);
      chk({28'h0, hs, sel, taken}, {28'h0, eHs, eSel, eUse});
   endtask
   // Applies reset for two clock cycles.
   task automatic doReset;
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, nErrors);
      if (nErrors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (5000) @(posedge core_clk);
      nErrors++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      stop_test();
   end
   // Main sequence: reception endpoint, status override, then transmission endpoint.
   initial begin
      rst = 1'b1;
      avsAddress = 4'h0;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsWritedata = 32'h0;
      avsByteenable = 4'hf;
      doReset();
      rdChk(4'h0, 16'h0000);
      rdChk(4'h4, 16'h0000);
      avAccess(1'b0, 4'h0, 16'hb1c0, 4'hc);
      rdChk(4'h0, 16'h0000);
      wr(4'h0, 16'hb1c0);
      rdChk(4'h0, 16'h3140);
      tok(1'b0, 0, 1'b1, 10'h012, UBD_HS_ACK, 1'b0, 1'b1);
      rdChk(4'h0, 16'he140);
      rdChk(4'h4, 16'h0003);
      rdChk(4'h8, 16'h0012);
      wr(4'h0, 16'h3100);
      rdChk(4'h0, 16'h7140);
      tok(1'b0, 0, 1'b1, 10'h011, UBD_HS_NAK, 1'b1, 1'b0);
      wr(4'h0, 16'h3140);
      tok(1'b0, 3, 1'b1, 10'h020, UBD_HS_ACK, 1'b1, 1'b1);
      rdChk(4'h0, 16'hb100);
      rdChk(4'hc, 16'h0020);
      tok(1'b0, 0, 1'b1, 10'h021, UBD_HS_NAK, 1'b0, 1'b0);
      wr(4'h0, 16'h3140);
      $display("Test reception flow done");
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, 16'h0100 | (16'(i) << 12));
         tok(1'b0, 1, 1'b0, 10'h005, statHs[i], 1'b0, i == 3);
      end
      rdChk(4'h0, 16'h3140);
      wr(4'h0, 16'h3000);
      rdChk(4'h4, 16'h0002);
      wr(4'h0, 16'h3300);
      tok(1'b0, 0, 1'b1, 10'h003, UBD_HS_ACK, 1'b0, 1'b1);
      rdChk(4'h0, 16'he340);
      rdChk(4'h4, 16'h0002);
      $display("Test status override done");
      doReset();
      wr(4'h0, 16'hc1b0);
      rdChk(4'h0, 16'h4130);
      tok(1'b1, 0, 1'b1, 10'h008, UBD_HS_ACK, 1'b0, 1'b1);
      rdChk(4'h0, 16'h41e0);
      rdChk(4'h4, 16'h0001);
      wr(4'h0, 16'h0130);
      tok(1'b1, 0, 1'b1, 10'h008, UBD_HS_NAK, 1'b1, 1'b0);
      wr(4'h0, 16'h4130);
      tok(1'b1, 2, 1'b1, 10'h008, UBD_HS_ACK, 1'b1, 1'b1);
      rdChk(4'h0, 16'h01b0);
      $display("Test transmission flow done");
      stop_test();
   end
endmodule
